// *** sloc_pkg.sv ***
package sloc_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W     = 8;
  localparam int ADDR_W     = 8;
  localparam int CNT_W      = 20;
  localparam int ERR_W      = 5;
  localparam int FIFO_DEPTH = 4;
  localparam int STREAM_W   = DATA_W + 4;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MASTER    = 8'h00;
  localparam logic [7:0] ADDR_TX_SCR    = 8'h14;
  localparam logic [7:0] ADDR_TX_SOH    = 8'h15;
  localparam logic [7:0] ADDR_RX_STAT   = 8'h18;
  localparam logic [7:0] ADDR_RX_IRQ    = 8'h19;
  localparam logic [7:0] ADDR_B2_LOW    = 8'h1A;
  localparam logic [7:0] ADDR_B2_MID    = 8'h1B;
  localparam logic [7:0] ADDR_B2_HIGH   = 8'h1C;
  localparam logic [7:0] ADDR_FEBE_LOW  = 8'h1D;
  localparam logic [7:0] ADDR_FEBE_MID  = 8'h1E;
  localparam logic [7:0] ADDR_FEBE_HIGH = 8'h1F;
  localparam logic [7:0] ADDR_TX_RDI    = 8'h20;
  localparam logic [7:0] ADDR_TX_B2FLIP = 8'h21;
  localparam logic [7:0] ADDR_TX_K1     = 8'h24;
  localparam logic [7:0] ADDR_TX_K2     = 8'h25;
  localparam logic [7:0] ADDR_RX_K1     = 8'h26;
  localparam logic [7:0] ADDR_RX_K2     = 8'h27;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_SCR_OFF    = 6;
  localparam int BIT_ALARM_INS  = 0;
  localparam int BIT_LOS_INS    = 2;
  localparam int BIT_B1_INV     = 1;
  localparam int BIT_FR_ERR     = 0;
  localparam int BIT_BLOCK_MODE = 7;
  localparam int BIT_ALARM_ST   = 1;
  localparam int BIT_RDI_ST     = 0;
  localparam int BIT_IEN_LO     = 4;
  localparam int BIT_RDI_INS    = 0;
  localparam int BIT_B2_INV     = 0;
  // flag / enable order inside the 4-bit groups: febe, b2, alarm, rdi
  localparam int FL_FEBE  = 3;
  localparam int FL_B2    = 2;
  localparam int FL_ALARM = 1;
  localparam int FL_RDI   = 0;
  // ----------------------------------------------------------------
  // reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] A1_MSB_MASK  = 8'h80;
  localparam logic [7:0] ALL_ONES     = 8'hFF;
  localparam logic [2:0] K2_RDI_CODE  = 3'h6;
  localparam logic [6:0] SCR_SEED     = 7'h7F;
  localparam logic [ERR_W-1:0] B2_MAX_STS1 = 5'h08;
  localparam logic [ERR_W-1:0] B2_MAX_STS3 = 5'h18;
  localparam logic [1:0] K_PERSIST    = 2'h3;
  // ----------------------------------------------------------------
  // transmit byte classes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CLS_PAYLOAD = 3'b000,
    CLS_SOH     = 3'b001,
    CLS_A1      = 3'b010,
    CLS_NOSCR   = 3'b011,
    CLS_B1      = 3'b100,
    CLS_B2      = 3'b101,
    CLS_K1      = 3'b110,
    CLS_K2      = 3'b111
  } sloc_class_t;
endpackage

// *** sloc_stream_if.sv ***
interface sloc_stream_if #(parameter int W = 12) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// *** sloc_fifo.sv ***
module sloc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic         clk,
  input wire logic         rst,
  sloc_stream_if.snk       inPort,
  sloc_stream_if.src       outPort
);
  import sloc_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [PW:0]      count_reg;
  logic [PW:0]      count_next;
  logic             ready_reg;
  logic             push;
  logic             pop;

  assign push         = inPort.valid && ready_reg;
  assign pop          = outPort.ready && (count_reg != '0);
  assign inPort.ready = ready_reg;
  assign outPort.valid = (count_reg != '0);
  assign outPort.data = mem[rdPtr_reg];

  always_comb begin
    count_next = count_reg + (PW + 1)'(push) - (PW + 1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inPort.data;
    end
  end

  // ready comes from a flop so the upstream never sees a combinational path
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      if (push) wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      if (pop) rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      count_reg <= count_next;
      ready_reg <= (count_next < DEPTH_C);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
    count_reg <= DEPTH_C) else $error("fifo count above depth");
endmodule

// *** sloc_poll_counter.sv ***
module sloc_poll_counter #(
  parameter int CW = 20,
  parameter int IW = 5
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          incValid,
  input  wire logic [IW-1:0] incAmount,
  input  wire logic          poll,
  output logic [CW-1:0]      heldCount
);
  import sloc_pkg::*;
  logic [CW-1:0] live_reg;
  logic [CW-1:0] held_reg;
  logic [CW-1:0] inc;

  assign inc       = incValid ? CW'(incAmount) : '0;
  assign heldCount = held_reg;

  // a coincident event goes into the fresh accumulation, never dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      live_reg <= '0;
      held_reg <= '0;
    end else if (poll) begin
      held_reg <= live_reg;
      live_reg <= inc;
    end else begin
      live_reg <= live_reg + inc;
    end
  end

  a_poll_holds: assert property (@(posedge clk) disable iff (rst)
    poll |=> held_reg == $past(live_reg)) else $error("poll did not hold count");
  a_poll_keeps_event: assert property (@(posedge clk) disable iff (rst)
    poll && incValid |=> live_reg == CW'($past(incAmount))) else $error("event lost");
endmodule

// *** sloc_top.sv ***
// What this block does
// - scrambler-disable bit set sends frame unscrambled; clear means scrambling active.
// - line alarm insert forces non-section-overhead bits to one before scrambling.
// - signal-loss insert forces the whole transmit stream to zeros.
// - section parity invert flips the computed B1 byte.
// - framing-error insert flips A1 msb, sending 0x76 instead of 0xf6.
// - B2 block mode adds one per errored frame, else adds the frame's errors; FEBE always adds the errors.
// - per-error mode caps B2 errors at 8 (STS-1) or 24 (STS-3c).
// - read-only bits show current line alarm and line remote defect.
// - enabled events raise the interrupt output.
// - latched flags for FEBE, B2 error, alarm change and defect change.
// - reading the flag register clears all four flags.
// - 20-bit B2 error count read over three byte locations.
// - 20-bit far-end block error count read over three byte locations.
// - write to a counter byte or master address polls both counters.
// - a poll copies the count to a holding register and restarts at zero.
// - an event in the poll cycle is still counted.
// - master-address write polls every receive error counter of the chip.
// - remote defect insert sends 110 in K2's three low bits.
// - line parity invert flips the computed B2 byte.
// - programmed second protection byte goes out in every K2.
// - receive defects override K2's low four bits.
// - programmed first protection byte goes out in every K1.
// - received K1/K2 registers update after 3 equal consecutive frames.
module sloc_top (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [sloc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [sloc_pkg::DATA_W-1:0] regWrData,
  input  wire logic                    regWrEn,
  input  wire logic                    regRdEn,
  output logic [sloc_pkg::DATA_W-1:0]  regRdData,
  input  wire logic [sloc_pkg::DATA_W-1:0] txInData,
  input  wire sloc_pkg::sloc_class_t   txInClass,
  input  wire logic                    txInSof,
  input  wire logic                    txInValid,
  output logic                         txInReady,
  output logic [sloc_pkg::DATA_W-1:0]  txOutData,
  output logic                         txOutValid,
  input  wire logic                    txOutReady,
  input  wire logic                    rxDefectOverride,
  input  wire logic [3:0]              rxDefectK2Low,
  input  wire logic                    rxLineAlarm,
  input  wire logic                    rxLineRdi,
  input  wire logic                    rxB2Valid,
  input  wire logic [sloc_pkg::ERR_W-1:0] rxB2Errors,
  input  wire logic                    rxFebeValid,
  input  wire logic [sloc_pkg::ERR_W-1:0] rxFebeErrors,
  input  wire logic                    stsThreeMode,
  input  wire logic                    rxKValid,
  input  wire logic [sloc_pkg::DATA_W-1:0] rxK1,
  input  wire logic [sloc_pkg::DATA_W-1:0] rxK2,
  output logic                         lineOhIrq,
  output logic                         pollAll
);
  import sloc_pkg::*;

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic       scrOff_reg, alarmIns_reg, signal_loss_insert_reg, section_parity_invert_reg, frErr_reg;
  logic       blockMode_reg, rdiIns_reg, line_parity_invert_reg;
  logic [3:0] irqEn_reg;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic [7:0] tx_protection_byte1_reg, tx_protection_byte2_reg;
  logic [7:0] rdData_reg;
  logic       irq_reg, pollAll_reg;
  logic       alarmState_reg, rdiState_reg;
  logic       wrHit, rdFlags, pollReq;

  assign wrHit   = regWrEn;
  assign rdFlags = regRdEn && (regAddr == ADDR_RX_IRQ);
  assign pollReq = regWrEn && ((regAddr == ADDR_MASTER) ||
                   ((regAddr >= ADDR_B2_LOW) && (regAddr <= ADDR_FEBE_HIGH)));

  always_ff @(posedge clk) begin
    if (rst) begin
      scrOff_reg    <= RST_BYTE[0];
      alarmIns_reg  <= RST_BYTE[0];
      signal_loss_insert_reg    <= RST_BYTE[0];
      section_parity_invert_reg     <= RST_BYTE[0];
      frErr_reg     <= RST_BYTE[0];
      blockMode_reg <= RST_BYTE[0];
      rdiIns_reg    <= RST_BYTE[0];
      line_parity_invert_reg     <= RST_BYTE[0];
      irqEn_reg     <= RST_BYTE[3:0];
      tx_protection_byte1_reg     <= RST_BYTE;
      tx_protection_byte2_reg     <= RST_BYTE;
    end else if (wrHit) begin
      case (regAddr)
        ADDR_TX_SCR: begin
          scrOff_reg   <= regWrData[BIT_SCR_OFF];
          alarmIns_reg <= regWrData[BIT_ALARM_INS];
        end
        ADDR_TX_SOH: begin
          signal_loss_insert_reg <= regWrData[BIT_LOS_INS];
          section_parity_invert_reg  <= regWrData[BIT_B1_INV];
          frErr_reg  <= regWrData[BIT_FR_ERR];
        end
        ADDR_RX_STAT:  blockMode_reg <= regWrData[BIT_BLOCK_MODE];
        ADDR_RX_IRQ:   irqEn_reg <= regWrData[BIT_IEN_LO +: 4];
        ADDR_TX_RDI:   rdiIns_reg <= regWrData[BIT_RDI_INS];
        ADDR_TX_B2FLIP: line_parity_invert_reg <= regWrData[BIT_B2_INV];
        ADDR_TX_K1:    tx_protection_byte1_reg <= regWrData;
        ADDR_TX_K2:    tx_protection_byte2_reg <= regWrData;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // receive line events and flags
  // ----------------------------------------------------------------
  logic [3:0] events;

  always_comb begin
    events           = 4'h0;
    events[FL_FEBE]  = rxFebeValid && (rxFebeErrors != '0);
    events[FL_B2]    = rxB2Valid && (rxB2Errors != '0);
    events[FL_ALARM] = (rxLineAlarm != alarmState_reg);
    events[FL_RDI]   = (rxLineRdi != rdiState_reg);
    // set wins over the read clear so an event in the read cycle survives
    flags_next = (rdFlags ? 4'h0 : flags_reg) | events;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      alarmState_reg <= 1'b0;
      rdiState_reg   <= 1'b0;
      flags_reg      <= 4'h0;
      irq_reg        <= 1'b0;
    end else begin
      alarmState_reg <= rxLineAlarm;
      rdiState_reg   <= rxLineRdi;
      flags_reg      <= flags_next;
      irq_reg        <= |(flags_next & irqEn_reg);
    end
  end

  // ----------------------------------------------------------------
  // line error counters
  // ----------------------------------------------------------------
  logic [ERR_W-1:0] b2Cap, b2Amount;
  logic [CNT_W-1:0] b2Held, febeHeld;

  always_comb begin
    b2Cap = stsThreeMode ? B2_MAX_STS3 : B2_MAX_STS1;
    if (blockMode_reg) begin
      b2Amount = (rxB2Errors != '0) ? ERR_W'(1) : '0;
    end else begin
      b2Amount = (rxB2Errors > b2Cap) ? b2Cap : rxB2Errors;
    end
  end

  sloc_poll_counter #(.CW(CNT_W), .IW(ERR_W)) b2Counter (
    .clk       (clk),
    .rst       (rst),
    .incValid  (rxB2Valid),
    .incAmount (b2Amount),
    .poll      (pollReq),
    .heldCount (b2Held)
  );

  sloc_poll_counter #(.CW(CNT_W), .IW(ERR_W)) febeCounter (
    .clk       (clk),
    .rst       (rst),
    .incValid  (rxFebeValid),
    .incAmount (rxFebeErrors),
    .poll      (pollReq),
    .heldCount (febeHeld)
  );

  // the rest of the chip's counters listen to this strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      pollAll_reg <= 1'b0;
    end else begin
      pollAll_reg <= regWrEn && (regAddr == ADDR_MASTER);
    end
  end

  // ----------------------------------------------------------------
  // received protection bytes
  // ----------------------------------------------------------------
  logic [7:0] kIn   [2];
  logic [7:0] kCand_reg [2];
  logic [1:0] kCnt_reg  [2];
  logic [7:0] kAcc_reg  [2];

  assign kIn[0] = rxK1;
  assign kIn[1] = rxK2;

  for (genvar g = 0; g < 2; g++) begin : gKeep
    always_ff @(posedge clk) begin
      if (rst) begin
        kCand_reg[g] <= RST_BYTE;
        kCnt_reg[g]  <= 2'h0;
        kAcc_reg[g]  <= RST_BYTE;
      end else if (rxKValid) begin
        if (kIn[g] == kCand_reg[g]) begin
          if (kCnt_reg[g] < K_PERSIST) kCnt_reg[g] <= kCnt_reg[g] + 2'h1;
          if (kCnt_reg[g] == K_PERSIST - 2'h1) kAcc_reg[g] <= kIn[g];
        end else begin
          kCand_reg[g] <= kIn[g];
          kCnt_reg[g]  <= 2'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_reg <= RST_BYTE;
    end else if (regRdEn) begin
      case (regAddr)
        ADDR_TX_SCR:    rdData_reg <= {1'b0, scrOff_reg, 5'h00, alarmIns_reg};
        ADDR_TX_SOH:    rdData_reg <= {5'h00, signal_loss_insert_reg, section_parity_invert_reg, frErr_reg};
        ADDR_RX_STAT:   rdData_reg <= {blockMode_reg, 5'h00, alarmState_reg, rdiState_reg};
        ADDR_RX_IRQ:    rdData_reg <= {irqEn_reg, flags_reg};
        ADDR_B2_LOW:    rdData_reg <= b2Held[7:0];
        ADDR_B2_MID:    rdData_reg <= b2Held[15:8];
        ADDR_B2_HIGH:   rdData_reg <= {4'h0, b2Held[19:16]};
        ADDR_FEBE_LOW:  rdData_reg <= febeHeld[7:0];
        ADDR_FEBE_MID:  rdData_reg <= febeHeld[15:8];
        ADDR_FEBE_HIGH: rdData_reg <= {4'h0, febeHeld[19:16]};
        ADDR_TX_RDI:    rdData_reg <= {7'h00, rdiIns_reg};
        ADDR_TX_B2FLIP: rdData_reg <= {7'h00, line_parity_invert_reg};
        ADDR_TX_K1:     rdData_reg <= tx_protection_byte1_reg;
        ADDR_TX_K2:     rdData_reg <= tx_protection_byte2_reg;
        ADDR_RX_K1:     rdData_reg <= kAcc_reg[0];
        ADDR_RX_K2:     rdData_reg <= kAcc_reg[1];
        default:        rdData_reg <= RST_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmit path
  // ----------------------------------------------------------------
  sloc_stream_if #(.W(STREAM_W)) fifoIn ();
  sloc_stream_if #(.W(STREAM_W)) fifoOut ();

  assign fifoIn.data  = {txInSof, txInClass, txInData};
  assign fifoIn.valid = txInValid;
  assign txInReady    = fifoIn.ready;

  sloc_fifo #(.WIDTH(STREAM_W), .DEPTH(FIFO_DEPTH)) txFifo (
    .clk     (clk),
    .rst     (rst),
    .inPort  (fifoIn.snk),
    .outPort (fifoOut.src)
  );

  function automatic logic [14:0] scrStep(input logic [6:0] s);
    logic [6:0] st;
    logic [7:0] mask;
    st   = s;
    mask = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      mask[i] = st[6];
      st      = {st[5:0], st[6] ^ st[5]};
    end
    return {st, mask};
  endfunction

  logic [6:0]  ctrlBits, activeCtrl_reg, effCtrl;
  logic        effScrOff, effAlarm, effLos, effB1Inv, effFrErr, effRdi, effB2Inv;
  logic [7:0]  headData, modByte, outByte;
  sloc_class_t headClass;
  logic        headSof, pop, sofPop, scrambled;
  logic [6:0]  scrState_reg, scrBase;
  logic [14:0] scrRes;
  logic [7:0]  txData_reg;
  logic        txValid_reg;

  assign headData  = fifoOut.data[DATA_W-1:0];
  assign headClass = sloc_class_t'(fifoOut.data[DATA_W +: 3]);
  assign headSof   = fifoOut.data[STREAM_W-1];
  assign fifoOut.ready = !txValid_reg || txOutReady;
  assign pop       = fifoOut.valid && fifoOut.ready;
  assign sofPop    = pop && headSof;
  assign ctrlBits  = {scrOff_reg, alarmIns_reg, signal_loss_insert_reg, section_parity_invert_reg,
                      frErr_reg, rdiIns_reg, line_parity_invert_reg};
  // controls only switch on the first byte of a frame
  assign effCtrl   = sofPop ? ctrlBits : activeCtrl_reg;
  assign {effScrOff, effAlarm, effLos, effB1Inv, effFrErr, effRdi, effB2Inv} = effCtrl;
  // framing row bytes stay in the clear
  assign scrambled = (headClass != CLS_A1) && (headClass != CLS_NOSCR);
  assign scrBase   = headSof ? SCR_SEED : scrState_reg;
  assign scrRes    = scrStep(scrBase);

  always_comb begin
    modByte = headData;
    case (headClass)
      CLS_A1: modByte = effFrErr ? (headData ^ A1_MSB_MASK) : headData;
      CLS_B1: modByte = effB1Inv ? ~headData : headData;
      CLS_B2: modByte = effB2Inv ? ~headData : headData;
      CLS_K1: modByte = tx_protection_byte1_reg;
      CLS_K2: begin
        modByte = tx_protection_byte2_reg;
        if (effRdi) modByte[2:0] = K2_RDI_CODE;
        if (rxDefectOverride) modByte[3:0] = rxDefectK2Low;
      end
      default: modByte = headData;
    endcase
    // line alarm covers everything but section overhead, ahead of the scrambler
    if (effAlarm && (headClass inside {CLS_PAYLOAD, CLS_B2, CLS_K1, CLS_K2})) begin
      modByte = ALL_ONES;
    end
    outByte = (scrambled && !effScrOff) ? (modByte ^ scrRes[7:0]) : modByte;
    if (effLos) outByte = 8'h00;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      activeCtrl_reg <= 7'h00;
      scrState_reg   <= SCR_SEED;
    end else if (pop) begin
      activeCtrl_reg <= effCtrl;
      if (scrambled) scrState_reg <= scrRes[14:8];
      else if (headSof) scrState_reg <= SCR_SEED;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txData_reg  <= 8'h00;
      txValid_reg <= 1'b0;
    end else if (fifoOut.ready) begin
      txValid_reg <= fifoOut.valid;
      if (pop) txData_reg <= outByte;
    end
  end

  assign txOutData  = txData_reg;
  assign txOutValid = txValid_reg;
  assign regRdData  = rdData_reg;
  assign lineOhIrq  = irq_reg;
  assign pollAll    = pollAll_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_los_all_zero: assert property (@(posedge clk) disable iff (rst)
    pop && effLos |=> txOutData == 8'h00) else $error("loss insert not zero");
  a_scr_bypass: assert property (@(posedge clk) disable iff (rst)
    pop && effScrOff && !effLos && !effAlarm && headClass == CLS_PAYLOAD
    |=> txOutData == $past(headData)) else $error("scrambler not bypassed");
  a_alarm_ones: assert property (@(posedge clk) disable iff (rst)
    pop && effAlarm && effScrOff && !effLos && headClass == CLS_PAYLOAD
    |=> txOutData == ALL_ONES) else $error("line alarm not all ones");
  a_a1_flip: assert property (@(posedge clk) disable iff (rst)
    pop && effFrErr && !effLos && headClass == CLS_A1
    |=> txOutData == ($past(headData) ^ A1_MSB_MASK)) else $error("A1 msb not flipped");
  a_b1_invert: assert property (@(posedge clk) disable iff (rst)
    pop && effB1Inv && effScrOff && !effLos && headClass == CLS_B1
    |=> txOutData == ~$past(headData)) else $error("B1 not inverted");
  a_k2_rdi_code: assert property (@(posedge clk) disable iff (rst)
    pop && effRdi && effScrOff && !effLos && !effAlarm && !rxDefectOverride
    && headClass == CLS_K2 |=> txOutData[2:0] == K2_RDI_CODE) else $error("K2 rdi code");
  a_flags_cleared: assert property (@(posedge clk) disable iff (rst)
    rdFlags && events == 4'h0 |=> flags_reg == 4'h0) else $error("flags not cleared");
  a_master_poll: assert property (@(posedge clk) disable iff (rst)
    regWrEn && regAddr == ADDR_MASTER |=> pollAll ##1 !pollAll) else $error("poll strobe");
  a_ctrl_at_frame: assert property (@(posedge clk) disable iff (rst)
    !sofPop |=> activeCtrl_reg == $past(activeCtrl_reg)) else $error("ctrl changed mid frame");
endmodule

// *** sloc_line_sink.sv ***
module sloc_line_sink (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [7:0] data,
  input  wire logic       valid,
  output logic            ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  initial ready = 1'b0;
  // slow mode stalls every other cycle so the fifo backs up
  always @(posedge clk) begin
    if (valid && ready) got.push_back(data);
    ready <= slow ? ~ready : 1'b1;
  end
endmodule

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sloc_pkg::*;
  logic clk, rst, regWrEn, regRdEn, txInSof, txInValid, txInReady, txOutValid;
  logic txOutReady, rxDefectOverride, rxLineAlarm, rxLineRdi, rxB2Valid;
  logic rxFebeValid, stsThreeMode, rxKValid, lineOhIrq, pollAll, slow;
  logic [7:0] regAddr, regWrData, regRdData, txInData, txOutData, rxK1, rxK2;
  logic [3:0] rxDefectK2Low;
  logic [ERR_W-1:0] rxB2Errors, rxFebeErrors;
  sloc_class_t txInClass;
  int fails, samples_checked;
  // reset values of writable registers plus one unmapped address
  localparam logic [7:0] ADDRS[9] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h20, 8'h21,
    8'h24, 8'h25, 8'h30};
  localparam logic [7:0] CNT[6] = '{8'h0B, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00};
  sloc_top i_sloc_top (.*);
  sloc_line_sink i_sloc_line_sink (.clk(clk), .slow(slow), .data(txOutData),
    .valid(txOutValid), .ready(txOutReady));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 chk($sformatf("reg%h", a), regRdData, e);
  endtask
  task automatic ev(logic [4:0] b, logic [4:0] f);
    @(posedge clk);
    {rxB2Valid, rxFebeValid, rxB2Errors, rxFebeErrors} <= {2'b11, b, f};
    @(posedge clk);
    {rxB2Valid, rxFebeValid} <= 2'b00;
  endtask
  task automatic kin(logic [7:0] v);
    @(posedge clk);
    {rxKValid, rxK1, rxK2} <= {1'b1, v, ~v};
    @(posedge clk);
    rxKValid <= 1'b0;
  endtask
  // one frame: a1 b1 b2 k1 k2 payload, compared after the stalling sink
  task automatic frame(logic [47:0] e);
    sloc_class_t c[6] = '{CLS_A1, CLS_B1, CLS_B2, CLS_K1, CLS_K2, CLS_PAYLOAD};
    logic [47:0] d = 48'hF6_12_12_00_00_55;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      {txInValid, txInSof} <= {1'b1, i == 0};
      txInClass <= c[i];
      txInData <= d[47-8*i -: 8];
      do @(negedge clk); while (txInReady !== 1'b1);
    end
    @(posedge clk);
    txInValid <= 1'b0;
    for (int n = 0; n < 60 && i_sloc_line_sink.got.size() < 6; n++) @(posedge clk);
    chk("txcount", 8'(i_sloc_line_sink.got.size()), 8'h06);
    for (int i = 0; i < 6; i++)
      chk("tx", i_sloc_line_sink.got.pop_front(), e[47-8*i -: 8]);
    $display("frame test done");
  endtask
  task automatic close_out();
    $display("compared %0d mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100us;
    fails++;
    close_out();
  end
  initial begin
    {regWrEn, regRdEn, txInSof, txInValid, rxDefectOverride, rxLineAlarm} = '0;
    {rxLineRdi, rxB2Valid, rxFebeValid, stsThreeMode, rxKValid, rxDefectK2Low} = '0;
    {regAddr, regWrData, txInData, rxK1, rxK2, rxB2Errors, rxFebeErrors} = '0;
    txInClass = CLS_PAYLOAD;
    slow = 1'b1;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
    wr(8'h14, 8'h40);
    wr(8'h24, 8'hA5);
    wr(8'h25, 8'h3C);
    frame(48'hF6_12_12_A5_3C_55);
    wr(8'h15, 8'h03);
    wr(8'h20, 8'h01);
    wr(8'h21, 8'h01);
    frame(48'h76_ED_ED_A5_3E_55);
    wr(8'h15, 8'h00);
    wr(8'h20, 8'h00);
    wr(8'h21, 8'h00);
    wr(8'h14, 8'h41);
    frame(48'hF6_12_FF_FF_FF_FF);
    wr(8'h15, 8'h04);
    frame(48'h00_00_00_00_00_00);
    wr(8'h15, 8'h00);
    wr(8'h14, 8'h00);
    {rxDefectOverride, rxDefectK2Low} <= 5'h15;
    frame(48'hF6_EC_16_BD_64_B1);
    wr(8'h14, 8'h01);
    frame(48'hF6_EC_FB_E7_AE_1B);
    ev(5'h1E, 5'h1E);
    ev(5'h03, 5'h01);
    wr(8'h00, 8'h00);
    #1 chk("poll", {7'h00, pollAll}, 8'h01);
    foreach (CNT[i]) rd(8'h1A + 8'(i), CNT[i]);
    rd(8'h19, 8'h0C);
    rd(8'h19, 8'h00);
    stsThreeMode <= 1'b1;
    ev(5'h1E, 5'h00);
    wr(8'h1F, 8'h00);
    rd(8'h1A, 8'h18);
    wr(8'h18, 8'h80);
    ev(5'h05, 5'h00);
    wr(8'h1D, 8'h00);
    rd(8'h1A, 8'h01);
    fork
      ev(5'h02, 5'h00);
      wr(8'h1A, 8'h00);
    join
    wr(8'h1A, 8'h00);
    rd(8'h1A, 8'h01);
    $display("counter test done");
    rd(8'h19, 8'h04);
    wr(8'h19, 8'hF0);
    rxLineAlarm <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("irq", {7'h00, lineOhIrq}, 8'h01);
    rd(8'h18, 8'h82);
    rd(8'h19, 8'hF2);
    wr(8'h19, 8'h00);
    rxLineRdi <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("irq", {7'h00, lineOhIrq}, 8'h00);
    rd(8'h19, 8'h01);
    kin(8'h11);
    kin(8'h11);
    rd(8'h26, 8'h00);
    kin(8'h11);
    rd(8'h26, 8'h11);
    rd(8'h27, 8'hEE);
    $display("status test done");
    close_out();
  end
endmodule
